// ==== common/flic_defs.vh ====
// Constants of the four-level interrupt controller: register offsets,
// field positions, reset values, source numbers and vector layout.
// Assumes an 8-bit register port with a 5-bit word address.
`ifndef FLIC_DEFS_VH
`define FLIC_DEFS_VH

`define FLIC_NUM_SRC 24
`define FLIC_ADDR_W 5
`define FLIC_DATA_W 8

// Register offsets
`define FLIC_REG_CTRL 5'h00
`define FLIC_REG_EN0 5'h01
`define FLIC_REG_EN1 5'h02
`define FLIC_REG_EN2 5'h03
`define FLIC_REG_PRIL0 5'h04
`define FLIC_REG_PRIL1 5'h05
`define FLIC_REG_PRIL2 5'h06
`define FLIC_REG_PRIH0 5'h07
`define FLIC_REG_PRIH1 5'h08
`define FLIC_REG_PRIH2 5'h09
`define FLIC_REG_FLAGS 5'h0A
`define FLIC_REG_ACTIVE 5'h0B
`define FLIC_REG_PEND0 5'h0C
`define FLIC_REG_PEND1 5'h0D
`define FLIC_REG_PEND2 5'h0E
`define FLIC_REG_LAST 5'h0F

// Control register fields
`define FLIC_CTRL_GIE 0
`define FLIC_CTRL_ROUTE 1
`define FLIC_CTRL_TYPE_LSB 4

// Flags register fields: bits 3..0 external, then timer 0 and timer 1
`define FLIC_FLG_TMR0 4
`define FLIC_FLG_TMR1 5

// Reset values
`define FLIC_RST_BYTE 8'h00
`define FLIC_RST_SRC 24'h000000

// Source numbers
`define FLIC_SRC_EXT0 0
`define FLIC_SRC_TMR0 1
`define FLIC_SRC_EXT1 2
`define FLIC_SRC_TMR1 3
`define FLIC_SRC_EXT2 6
`define FLIC_SRC_EXT3 15
`define FLIC_SRC_FIXED_FIRST 19

// Vector layout and the level of the fixed sources
`define FLIC_VEC_BASE 16'h0003
`define FLIC_VEC_SHIFT 3
`define FLIC_PRI_TOP 2'h3

`endif

// ==== rtl/flic_ext_detect.v ====
// External request inputs: pin synchroniser and falling-edge detection.
// Assumes asynchronous active-low pins and one core clock with enable.
`timescale 1ns/1ns
module flic_ext_detect (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_ce,
    input wire [3:0] i_external_request_input_n,
    output wire [3:0] o_edge,
    output wire [3:0] o_level
);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            // Per-pin flops, so each has one driving process
            reg sync_a;
            reg sync_b;
            reg prev;
            // Two stages before use; idle pin level is high
            always @(posedge i_core_clk) begin
                if (i_rst) begin
                    sync_a <= 1'b1;
                    sync_b <= 1'b1;
                    prev <= 1'b1;
                end else if (i_ce) begin
                    sync_a <= i_external_request_input_n[g];
                    sync_b <= sync_a;
                    prev <= sync_b;
                end
            end
            // Falling edge pulse and low-level request
            assign o_edge[g] = prev & ~sync_b;
            assign o_level[g] = ~sync_b;
        end
    endgenerate
endmodule // flic_ext_detect

// ==== rtl/flic_arbiter.v ====
// Priority resolver: highest level wins, lowest source number breaks ties.
// Pure combinational; assumes requests already gated and sampled.
`timescale 1ns/1ns
`include "flic_defs.vh"
module flic_arbiter (
    input wire [`FLIC_NUM_SRC-1:0] i_req,
    input wire [2*`FLIC_NUM_SRC-1:0] i_pri,
    output reg o_valid,
    output reg [4:0] o_index,
    output reg [1:0] o_level
);
    integer n;

    // Scan downward so a lower number replaces an equal level
    always @* begin
        o_valid = 1'b0;
        o_index = 5'h00;
        o_level = 2'h0;
        for (n = `FLIC_NUM_SRC - 1; n >= 0; n = n - 1) begin
            if (i_req[n] && (!o_valid || i_pri[2*n +: 2] >= o_level)) begin
                o_valid = 1'b1;
                o_index = n[4:0];
                o_level = i_pri[2*n +: 2];
            end
        end
    end
endmodule // flic_arbiter

// ==== rtl/flic_top.v ====
// Four-level interrupt controller for a multi-cycle 8-bit core.
// Assumes peripheral flags arrive as levels on the core clock, external
// request pins are asynchronous, and the core pulses i_instr_last and i_reti.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "flic_defs.vh"
module flic_top (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_ce,
    // Register port
    input wire [`FLIC_ADDR_W-1:0] i_addr,
    input wire [`FLIC_DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [`FLIC_DATA_W-1:0] o_rdata,
    // External request pins, active low
    input wire [3:0] i_external_request_input_n,
    // Timer 0/1 rollover pulses
    input wire i_tmr0_overflow_event,
    input wire i_tmr1_overflow_event,
    // Peripheral flags, bit 0 is timer 2 / port 0 / engine 0
    input wire [2:0] i_tmr_overflow_flag,
    input wire [2:0] i_tmr_external_flag,
    input wire [2:0] i_tmr_low_byte_overflow,
    input wire [3:0] i_uart_rx_done,
    input wire [3:0] i_uart_tx_done,
    input wire i_dma_transfer_complete,
    input wire i_dma_tmr_a_overflow,
    input wire i_dma_tmr_b_overflow,
    input wire i_sync_port_xfer_done,
    input wire i_conv_complete_flag,
    input wire i_conv_window_flag,
    input wire i_conv_sample_flag,
    input wire i_array_counter_overflow,
    input wire [7:0] i_array_module_flag,
    input wire [9:0] i_sys_flags,
    input wire i_keypad_match_flag,
    input wire [1:0] i_twowire_state_flag,
    input wire [2:0] i_comparator_edge_flag,
    // Core handshake
    input wire i_instr_last,
    input wire i_reti,
    output reg o_call,
    output reg [15:0] o_vector
);
    // Control and configuration
    reg global_int_enable;
    reg tx_flag_route_enable;
    reg [3:0] ext_type_select;
    reg [`FLIC_NUM_SRC-1:0] src_enable;
    reg [`FLIC_NUM_SRC-1:0] pri_low;
    reg [`FLIC_NUM_SRC-1:0] pri_high;
    // Flags held here
    reg [3:0] ext_request_flag;
    reg tmr0_overflow_flag;
    reg tmr1_overflow_flag;
    // Sampling, service state and hold-off
    reg [`FLIC_NUM_SRC-1:0] pend;
    reg [3:0] active_level;
    reg wr_seen;
    reg [4:0] last_index;
    reg last_valid;

    wire [3:0] ext_edge;
    wire [3:0] ext_level;
    wire [`FLIC_NUM_SRC-1:0] raw_req;
    wire [`FLIC_NUM_SRC-1:0] gated_req;
    wire [2*`FLIC_NUM_SRC-1:0] eff_pri;
    wire win_valid;
    wire [4:0] win_index;
    wire [1:0] win_level;
    wire sys_req;
    wire wr_en;
    wire wr_flags;
    wire irq_reg_write;
    wire [2:0] act_top;
    wire level_ok;
    wire blocked;
    wire take_call;
    wire [3:0] ext_vec_clr;
    wire [3:0] next_ext_flag;
    wire next_tmr0_flag;
    wire next_tmr1_flag;
    wire [2:0] reti_top;

    // Highest in-service level: bit 2 says any, bits 1:0 the level code
    function [2:0] flic_top_level;
        input [3:0] act;
        begin
            if (act[3])
                flic_top_level = 3'h7;
            else if (act[2])
                flic_top_level = 3'h6;
            else if (act[1])
                flic_top_level = 3'h5;
            else if (act[0])
                flic_top_level = 3'h4;
            else
                flic_top_level = 3'h0;
        end
    endfunction

    // Pin synchronising and edge detection
    flic_ext_detect u_ext (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_external_request_input_n(i_external_request_input_n),
        .o_edge(ext_edge),
        .o_level(ext_level)
    );

    // System source; transmit done joins only when routed
    assign sys_req = (|i_sys_flags) | (tx_flag_route_enable & i_uart_tx_done[0]);

    // Per-source request; peripheral flags are never cleared here
    assign raw_req[0] = ext_request_flag[0];
    assign raw_req[1] = tmr0_overflow_flag;
    assign raw_req[2] = ext_request_flag[1];
    assign raw_req[3] = tmr1_overflow_flag;
    assign raw_req[4] = i_uart_rx_done[0] | i_uart_tx_done[0];
    assign raw_req[5] = i_tmr_overflow_flag[0] | i_tmr_external_flag[0] | i_tmr_low_byte_overflow[0];
    assign raw_req[6] = ext_request_flag[2];
    assign raw_req[7] = i_sync_port_xfer_done;
    assign raw_req[8] = i_conv_complete_flag | i_conv_window_flag | i_conv_sample_flag;
    assign raw_req[9] = i_array_counter_overflow | (|i_array_module_flag);
    assign raw_req[10] = sys_req;
    assign raw_req[11] = i_keypad_match_flag;
    assign raw_req[12] = i_twowire_state_flag[0];
    assign raw_req[13] = i_comparator_edge_flag[0];
    assign raw_req[14] = i_uart_rx_done[1] | i_uart_tx_done[1];
    assign raw_req[15] = ext_request_flag[3];
    assign raw_req[16] = i_tmr_overflow_flag[1] | i_tmr_external_flag[1] | i_tmr_low_byte_overflow[1];
    assign raw_req[17] = i_comparator_edge_flag[1];
    assign raw_req[18] = i_dma_transfer_complete | i_dma_tmr_a_overflow | i_dma_tmr_b_overflow;
    assign raw_req[19] = i_comparator_edge_flag[2];
    assign raw_req[20] = i_uart_rx_done[2] | i_uart_tx_done[2];
    assign raw_req[21] = i_tmr_overflow_flag[2] | i_tmr_external_flag[2] | i_tmr_low_byte_overflow[2];
    assign raw_req[22] = i_uart_rx_done[3] | i_uart_tx_done[3];
    assign raw_req[23] = i_twowire_state_flag[1];

    // Individual and global enable both needed
    assign gated_req = raw_req & src_enable & {`FLIC_NUM_SRC{global_int_enable}};

    // Level code per source; the top five have no priority bits
    genvar g;
    generate
        for (g = 0; g < `FLIC_NUM_SRC; g = g + 1) begin : g_pri
            if (g >= `FLIC_SRC_FIXED_FIRST) begin : g_fix
                assign eff_pri[2*g +: 2] = `FLIC_PRI_TOP;
            end else begin : g_var
                assign eff_pri[2*g +: 2] = {pri_high[g], pri_low[g]};
            end
        end
    endgenerate

    // Resolve the sampled requests
    flic_arbiter u_arb (
        .i_req(pend),
        .i_pri(eff_pri),
        .o_valid(win_valid),
        .o_index(win_index),
        .o_level(win_level)
    );

    // Register decode; any enable, priority or control write holds off a call
    assign wr_en = i_wr && (i_addr <= `FLIC_REG_PRIH2);
    assign wr_flags = i_wr && (i_addr == `FLIC_REG_FLAGS);
    assign irq_reg_write = wr_en;

    // Only a strictly higher level may preempt
    assign act_top = flic_top_level(active_level);
    assign level_ok = !act_top[2] || (win_level > act_top[1:0]);
    // Blocked by level, unfinished instruction, return or register write
    assign blocked = !level_ok || !i_instr_last || i_reti || wr_seen || irq_reg_write;
    assign take_call = win_valid && !blocked;

    // Vectoring clears external flags only for edge-mode inputs
    genvar e;
    generate
        for (e = 0; e < 4; e = e + 1) begin : g_extflag
            assign ext_vec_clr[e] = take_call && ext_type_select[e] && (win_index == (e == 0 ? `FLIC_SRC_EXT0 :
                e == 1 ? `FLIC_SRC_EXT1 : e == 2 ? `FLIC_SRC_EXT2 : `FLIC_SRC_EXT3));
            // Edge mode: sticky, edge wins over clear; level mode follows the pin
            assign next_ext_flag[e] = !ext_type_select[e] ? ext_level[e] :
                (ext_edge[e] ? 1'b1 : (ext_vec_clr[e] ? 1'b0 :
                (wr_flags ? i_wdata[e] : ext_request_flag[e])));
        end
    endgenerate

    // Timer flags: rollover wins, then vector clear, then software
    assign next_tmr0_flag = i_tmr0_overflow_event ? 1'b1 :
        ((take_call && win_index == `FLIC_SRC_TMR0) ? 1'b0 :
        (wr_flags ? i_wdata[`FLIC_FLG_TMR0] : tmr0_overflow_flag));
    assign next_tmr1_flag = i_tmr1_overflow_event ? 1'b1 :
        ((take_call && win_index == `FLIC_SRC_TMR1) ? 1'b0 :
        (wr_flags ? i_wdata[`FLIC_FLG_TMR1] : tmr1_overflow_flag));

    // Level released by a return: the topmost in service
    assign reti_top = flic_top_level(active_level);

    // Configuration registers written by software
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            global_int_enable <= 1'b0;
            tx_flag_route_enable <= 1'b0;
            ext_type_select <= 4'h0;
            src_enable <= `FLIC_RST_SRC;
            pri_low <= `FLIC_RST_SRC;
            pri_high <= `FLIC_RST_SRC;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `FLIC_REG_CTRL: begin
                    global_int_enable <= i_wdata[`FLIC_CTRL_GIE];
                    tx_flag_route_enable <= i_wdata[`FLIC_CTRL_ROUTE];
                    ext_type_select <= i_wdata[`FLIC_CTRL_TYPE_LSB +: 4];
                end
                `FLIC_REG_EN0: src_enable[7:0] <= i_wdata;
                `FLIC_REG_EN1: src_enable[15:8] <= i_wdata;
                `FLIC_REG_EN2: src_enable[23:16] <= i_wdata;
                `FLIC_REG_PRIL0: pri_low[7:0] <= i_wdata;
                `FLIC_REG_PRIL1: pri_low[15:8] <= i_wdata;
                `FLIC_REG_PRIL2: pri_low[23:16] <= i_wdata;
                `FLIC_REG_PRIH0: pri_high[7:0] <= i_wdata;
                `FLIC_REG_PRIH1: pri_high[15:8] <= i_wdata;
                `FLIC_REG_PRIH2: pri_high[23:16] <= i_wdata;
                default: ;
            endcase
        end
    end

    // Owned request flags
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_request_flag <= 4'h0;
            tmr0_overflow_flag <= 1'b0;
            tmr1_overflow_flag <= 1'b0;
        end else if (i_ce) begin
            ext_request_flag <= next_ext_flag;
            tmr0_overflow_flag <= next_tmr0_flag;
            tmr1_overflow_flag <= next_tmr1_flag;
        end
    end

    // Sample every clock; polling looks at last cycle's sample
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            pend <= `FLIC_RST_SRC;
        end else if (i_ce) begin
            pend <= gated_req;
        end
    end

    // Enable, priority and control writes block polling until the instruction ends
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_seen <= 1'b0;
        end else if (i_ce) begin
            if (i_instr_last)
                wr_seen <= 1'b0;
            else if (irq_reg_write)
                wr_seen <= 1'b1;
        end
    end

    // In-service levels; a call in the same cycle as a return is blocked
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            active_level <= 4'h0;
        end else if (i_ce) begin
            if (take_call)
                active_level[win_level] <= 1'b1;
            else if (i_reti && reti_top[2])
                active_level[reti_top[1:0]] <= 1'b0;
        end
    end

    // Call pulse and fixed entry address
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_call <= 1'b0;
            o_vector <= 16'h0000;
            last_index <= 5'h00;
            last_valid <= 1'b0;
        end else if (i_ce) begin
            o_call <= take_call;
            if (take_call) begin
                o_vector <= `FLIC_VEC_BASE + ({11'h000, win_index} << `FLIC_VEC_SHIFT);
                last_index <= win_index;
                last_valid <= 1'b1;
            end
        end
    end

    // Read data valid the cycle after the strobe only; unmapped reads zero
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= `FLIC_RST_BYTE;
        end else if (i_ce) begin
            if (i_rd) begin
                case (i_addr)
                    `FLIC_REG_CTRL: o_rdata <= {ext_type_select, 2'h0, tx_flag_route_enable, global_int_enable};
                    `FLIC_REG_EN0: o_rdata <= src_enable[7:0];
                    `FLIC_REG_EN1: o_rdata <= src_enable[15:8];
                    `FLIC_REG_EN2: o_rdata <= src_enable[23:16];
                    `FLIC_REG_PRIL0: o_rdata <= pri_low[7:0];
                    `FLIC_REG_PRIL1: o_rdata <= pri_low[15:8];
                    `FLIC_REG_PRIL2: o_rdata <= pri_low[23:16];
                    `FLIC_REG_PRIH0: o_rdata <= pri_high[7:0];
                    `FLIC_REG_PRIH1: o_rdata <= pri_high[15:8];
                    `FLIC_REG_PRIH2: o_rdata <= pri_high[23:16];
                    `FLIC_REG_FLAGS: o_rdata <= {2'h0, tmr1_overflow_flag, tmr0_overflow_flag, ext_request_flag};
                    `FLIC_REG_ACTIVE: o_rdata <= {4'h0, active_level};
                    `FLIC_REG_PEND0: o_rdata <= pend[7:0];
                    `FLIC_REG_PEND1: o_rdata <= pend[15:8];
                    `FLIC_REG_PEND2: o_rdata <= pend[23:16];
                    `FLIC_REG_LAST: o_rdata <= {last_valid, 2'h0, last_index};
                    default: o_rdata <= `FLIC_RST_BYTE;
                endcase
            end else begin
                o_rdata <= `FLIC_RST_BYTE;
            end
        end
    end
endmodule // flic_top

// ==== dv/flic_top_properties.sv ====
// Concurrent checks on the interrupt controller's ports.
// Assumes i_ce held high and a bind onto flic_top.
`timescale 1ns/1ns
module flic_top_checker (
    input wire i_core_clk,
    input wire i_rst,
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_instr_last,
    input wire i_reti,
    input wire o_call,
    input wire [15:0] o_vector
);
    reg gie;
    reg [2:0] depth;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Shadow of the global enable and call nesting; a fifth open call means a level was reused
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            gie <= 1'b0;
            depth <= 3'h0;
        end else begin
            if (i_wr && i_addr == 5'h00)
                gie <= i_wdata[0];
            depth <= depth + {2'h0, o_call} - {2'h0, i_reti && depth != 3'h0};
        end
    end
    call_on_last_a: assert property (o_call |-> $past(i_instr_last) && !$past(i_reti))
        else $error("call outside a final cycle or beside a return");
    write_block_a: assert property ($past(i_wr) && $past(i_addr) <= 5'h09 |-> !o_call)
        else $error("call right after a control write");
    vector_form_a: assert property (o_call |-> o_vector[2:0] == 3'h3 && o_vector <= 16'h00BB)
        else $error("vector off the entry grid");
    vector_hold_a: assert property (!o_call |-> $stable(o_vector))
        else $error("vector moved without a call");
    gie_gate_a: assert property (!gie && !$past(gie) && !$past(gie, 2) && !$past(gie, 3) |-> !o_call)
        else $error("call with global enable off");
    level_depth_a: assert property (depth <= 3'h4)
        else $error("more open calls than levels");
    read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its cycle");
    read_unmapped_a: assert property ($past(i_rd) && $past(i_addr) > 5'h0F |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (o_call);
    cover property (depth == 3'h3);
    cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule // flic_top_checker

bind flic_top flic_top_checker chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_instr_last(i_instr_last),
    .i_reti(i_reti), .o_call(o_call), .o_vector(o_vector));

// ==== dv/flic_core_model.sv ====
// Core model: marks final instruction cycles and executes returns.
// Assumes one core clock; the bench asks for each return.
`timescale 1ns/1ns
module flic_core_model (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_slow,
    input wire i_ret,
    output reg o_instr_last = 1'b0,
    output reg o_reti = 1'b0
);
    reg [7:0] lfsr = 8'hA5;
    // Slow mode leaves about half the cycles mid-instruction, so polls get refused
    always @(posedge i_core_clk) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        o_instr_last <= !i_rst && (!i_slow || lfsr[0]);
        o_reti <= i_ret && !i_rst;
    end
endmodule // flic_core_model

// ==== dv/flic_top_tb.sv ====
// Self-checking bench for the interrupt controller.
// Assumes the core model beside it; i_ce stays high throughout.
`timescale 1ns/1ns
module flic_top_tb;
    logic i_core_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00, i_array_module_flag = 8'h00, o_rdata;
    logic [3:0] i_external_request_input_n = 4'hF, i_uart_rx_done = 4'h0, i_uart_tx_done = 4'h0;
    logic i_tmr0_overflow_event = 1'b0, i_tmr1_overflow_event = 1'b0, i_sync_port_xfer_done = 1'b0;
    logic [2:0] i_tmr_overflow_flag = 3'h0, i_tmr_external_flag = 3'h0, i_tmr_low_byte_overflow = 3'h0;
    logic i_dma_transfer_complete = 1'b0, i_dma_tmr_a_overflow = 1'b0, i_dma_tmr_b_overflow = 1'b0;
    logic i_conv_complete_flag = 1'b0, i_conv_window_flag = 1'b0, i_conv_sample_flag = 1'b0;
    logic i_array_counter_overflow = 1'b0, i_keypad_match_flag = 1'b0, slow = 1'b0, ret_go = 1'b0;
    logic [9:0] i_sys_flags = 10'h000;
    logic [1:0] i_twowire_state_flag = 2'h0;
    logic [2:0] i_comparator_edge_flag = 3'h0;
    logic i_instr_last, i_reti, o_call;
    logic [15:0] o_vector;
    logic [31:0] seed = 32'h00000049;
    int err_count = 0, checks = 0, cyc = 0;
    // Bit index of each source inside its peripheral group
    int idx [24] = '{0, 0, 1, 0, 0, 0, 2, 0, 0, 0, 0, 0, 0, 0, 1, 3, 1, 1, 0, 2, 2, 2, 3, 1};

    always #4 i_core_clk = ~i_core_clk;

    flic_top dut_u (.i_core_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_external_request_input_n, .i_tmr0_overflow_event, .i_tmr1_overflow_event, .i_tmr_overflow_flag,
        .i_tmr_external_flag, .i_tmr_low_byte_overflow, .i_uart_rx_done, .i_uart_tx_done,
        .i_dma_transfer_complete, .i_dma_tmr_a_overflow, .i_dma_tmr_b_overflow, .i_sync_port_xfer_done,
        .i_conv_complete_flag, .i_conv_window_flag, .i_conv_sample_flag, .i_array_counter_overflow,
        .i_array_module_flag, .i_sys_flags, .i_keypad_match_flag, .i_twowire_state_flag,
        .i_comparator_edge_flag, .i_instr_last, .i_reti, .o_call, .o_vector);
    flic_core_model core_u (.i_core_clk, .i_rst, .i_slow(slow), .i_ret(ret_go), .o_instr_last(i_instr_last),
        .o_reti(i_reti));

    // Timer overflow events last one cycle; the cycle ceiling cuts a hang short
    always @(posedge i_core_clk) begin
        if (i_tmr0_overflow_event)
            i_tmr0_overflow_event <= 1'b0;
        if (i_tmr1_overflow_event)
            i_tmr1_overflow_event <= 1'b0;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [15:0] vec(input int s);
        return 16'h0003 + 16'(s * 8);
    endfunction
    // One random member of an ORed group, or none
    function logic [9:0] pick(input logic v, input int n);
        return v ? 10'(10'h001 << (xs() % n)) : 10'h000;
    endfunction
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tally_and_finish();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, o_rdata});
    endtask
    task wcall(input logic [15:0] e);
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1 n++;
        end while (o_call !== 1'b1 && n < 60);
        chk("vector", e, (o_call === 1'b1) ? o_vector : 16'hFFFF);
        @(posedge i_core_clk); // Hand back on an edge so stimulus lands there
    endtask
    task nocall(input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            #1 chk("call", 16'h0000, {15'h0000, o_call});
        end
        @(posedge i_core_clk);
    endtask
    task ret();
        @(posedge i_core_clk);
        ret_go <= 1'b1;
        @(posedge i_core_clk);
        ret_go <= 1'b0;
    endtask
    // Raise or drop source s through the peripheral input that feeds it
    task set_src(input int s, input logic v);
        logic [9:0] p;
        int k;
        p = pick(v, 3);
        k = idx[s];
        case (s)
            0, 2, 6, 15: i_external_request_input_n[k] <= ~v;
            1: i_tmr0_overflow_event <= v;
            3: i_tmr1_overflow_event <= v;
            4, 14, 20, 22: {i_uart_tx_done[k], i_uart_rx_done[k]} <= p[1:0] | {1'b0, p[2]};
            5, 16, 21: {i_tmr_low_byte_overflow[k], i_tmr_external_flag[k], i_tmr_overflow_flag[k]} <= p[2:0];
            7: i_sync_port_xfer_done <= v;
            8: {i_conv_sample_flag, i_conv_window_flag, i_conv_complete_flag} <= p[2:0];
            9: {i_array_module_flag, i_array_counter_overflow} <= 9'(pick(v, 9));
            10: i_sys_flags <= pick(v, 10);
            11: i_keypad_match_flag <= v;
            12, 23: i_twowire_state_flag[k] <= v;
            13, 17, 19: i_comparator_edge_flag[k] <= v;
            default: {i_dma_tmr_b_overflow, i_dma_tmr_a_overflow, i_dma_transfer_complete} <= p[2:0];
        endcase
    endtask

    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst <= 1'b0;
        wr(5'h1F, 8'hFF);
        wr(5'h0B, 8'hFF);
        for (int a = 0; a < 17; a++)
            rd(5'(a), 8'h00);
        for (int a = 1; a < 4; a++)
            wr(5'(a), 8'hFF);
        set_src(7, 1'b1);
        nocall(8);
        wr(5'h00, 8'h01);
        wcall(vec(7));
        set_src(7, 1'b0);
        ret();
        wr(5'h01, 8'h00);
        set_src(4, 1'b1);
        nocall(8);
        set_src(4, 1'b0);
        wr(5'h01, 8'hFF);
        // Every source in turn, the core answering fast or slow
        for (int s = 0; s < 24; s++) begin
            slow <= ^xs();
            set_src(s, 1'b1);
            wcall(vec(s));
            if (s == 0)
                rd(5'h0A, 8'h01);
            set_src(s, 1'b0);
            repeat (6) @(posedge i_core_clk);
            if (s == 1 || s == 3)
                rd(5'h0A, 8'h00);
            ret();
        end
        slow <= 1'b0;
        set_src(11, 1'b1);
        set_src(9, 1'b1);
        set_src(8, 1'b1);
        wcall(vec(8));
        for (int s = 8; s < 12; s++)
            set_src(s, 1'b0);
        repeat (4) @(posedge i_core_clk);
        ret();
        // External input 0 in edge mode: cleared on vectoring, kept while masked
        wr(5'h00, 8'h11);
        set_src(0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        set_src(0, 1'b0);
        wcall(vec(0));
        rd(5'h0A, 8'h00);
        ret();
        wr(5'h00, 8'h10);
        set_src(0, 1'b1);
        repeat (2) @(posedge i_core_clk);
        set_src(0, 1'b0);
        repeat (6) @(posedge i_core_clk);
        rd(5'h0A, 8'h01);
        wr(5'h0A, 8'h00);
        rd(5'h0A, 8'h00);
        wr(5'h00, 8'h01);
        wr(5'h0A, 8'h20);
        wcall(vec(3));
        ret();
        // Port 0 transmit reaches the system source only when routed
        wr(5'h01, 8'hEF);
        i_uart_tx_done[0] <= 1'b1;
        nocall(8);
        wr(5'h00, 8'h03);
        wcall(vec(10));
        i_uart_tx_done[0] <= 1'b0;
        wr(5'h00, 8'h01);
        wr(5'h01, 8'hFF);
        ret();
        // Levels: source 5 at 01, 13 at 10, 19 fixed on top, 2 at 00
        wr(5'h04, 8'h20);
        wr(5'h08, 8'h20);
        set_src(2, 1'b1);
        set_src(5, 1'b1);
        wcall(vec(5));
        rd(5'h0B, 8'h02);
        set_src(13, 1'b1);
        wcall(vec(13));
        set_src(19, 1'b1);
        wcall(vec(19));
        rd(5'h0B, 8'h0E);
        set_src(13, 1'b0);
        set_src(19, 1'b0);
        ret();
        ret();
        rd(5'h0B, 8'h02);
        nocall(10);
        set_src(5, 1'b0);
        ret();
        wcall(vec(2));
        set_src(2, 1'b0);
        ret();
        rd(5'h0B, 8'h00);
        tally_and_finish();
    end
endmodule // flic_top_tb
